// ### rtl/iot_map.svh
// iot_map.svh - codes and sizes of the io transaction tracker
// assumes it is included only through iot_pkg
`ifndef IOT_MAP_SVH
`define IOT_MAP_SVH
// packet format codes of requests
`define IOT_FT_NREAD   4'h2
`define IOT_FT_ATOMIC  4'h2
`define IOT_FT_NWRITE  4'h5
`define IOT_FT_SWRITE  4'h6
`define IOT_FT_MAINT   4'h8
// format code used on ordinary responses
`define IOT_FT_RESP    4'hD
// response status codes
`define IOT_ST_DONE    2'h0
`define IOT_ST_ERROR   2'h1
`define IOT_ST_RETRY   2'h2
// sizes
`define IOT_NUM_TID    4
`define IOT_FIFO_DEPTH 8
`endif

// ### rtl/iot_pkg.sv
// iot_pkg.sv - types and helpers of the io transaction tracker
// assumes iot_map.svh is on the include path
package iot_pkg;
`include "iot_map.svh"

    typedef enum logic [2:0] {
        K_NREAD    = 3'h0,
        K_NWRITE   = 3'h1,
        K_NWRITE_R = 3'h2,
        K_SWRITE   = 3'h3,
        K_ATOMIC   = 3'h4,
        K_MAINT    = 3'h5
    } iot_kind_type;

    typedef enum logic [1:0] {
        C_READ  = 2'h0,
        C_WRITE = 2'h1,
        C_NONE  = 2'h2
    } iot_class_type;

    // request kind to packet format
    function automatic logic [3:0] iot_ftype(input iot_kind_type k);
        unique case (k)
            K_NREAD:             iot_ftype = `IOT_FT_NREAD;
            K_ATOMIC:            iot_ftype = `IOT_FT_ATOMIC;
            K_NWRITE, K_NWRITE_R: iot_ftype = `IOT_FT_NWRITE;
            K_SWRITE:            iot_ftype = `IOT_FT_SWRITE;
            default:             iot_ftype = `IOT_FT_MAINT;
        endcase
    endfunction : iot_ftype

    // completion ordering class; maintenance stands outside it
    function automatic iot_class_type iot_class(input iot_kind_type k);
        if (k == K_MAINT) iot_class = C_NONE;
        else if (k == K_NREAD) iot_class = C_READ;
        else iot_class = C_WRITE;
    endfunction : iot_class

    // posted writes never get an answer
    function automatic logic iot_needs_resp(input iot_kind_type k);
        iot_needs_resp = (k != K_NWRITE) && (k != K_SWRITE);
    endfunction : iot_needs_resp
endpackage : iot_pkg

// ### rtl/iot_fifo.sv
// iot_fifo.sv - small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
module iot_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("iot_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          push;
    logic          pop;

    // flags are registered from the next count so both ready and valid are flops
    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign cnt_next   = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o = mem_reg[rd_reg];

    // storage has no reset; only pointers, count and flags need one
    always_ff @(posedge clk_sys_i) begin
        if (push) mem_reg[wr_reg] <= in_data_i;
    end

    // pointers, count and flags
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wr_reg      <= '0;
            rd_reg      <= '0;
            cnt_reg     <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
            cnt_reg     <= cnt_next;
            in_ready_o  <= cnt_next != (AW+1)'(DEPTH);
            out_valid_o <= cnt_next != '0;
        end
    end
endmodule : iot_fifo

// ### rtl/iot_tracker.sv
// iot_tracker.sv - request/response engine of an io endpoint
// assumes one clock, a memory port that answers with ack, and a packet
// link outside that takes tx words on valid/ready
`timescale 1ns/10ps

// Function
// - correctness never relies on arrival order
// - serial mode: reads/writes wait completion before next
// - finish each request before serving next
// - ordered: retry all later after one retry
// - on retry rewind and resend in order
// - transaction tags restore order at destination
// - never drop an accepted packet
// - input acceptance independent of output queue; here rq_ready_o drops when the buffer fills
// - answer when done or on error
// - nread reads memory, data in done
// - done means success, carries read data
// - error means unrecoverable target failure
// - unique tid per pair, match responses
// - never reuse an outstanding tid
// - out of sequence requests get retried
// - formats: nread 2, writes 5, swrite 6
// - maintenance format 8, no ordering class
// - posted writes: no response, no entry
module iot_tracker #(
    parameter int ADDR_W     = 32,
    parameter int DATA_W     = 64,
    parameter int ID_W       = 8,
    parameter int NUM_TID    = `IOT_NUM_TID,
    parameter int FIFO_DEPTH = `IOT_FIFO_DEPTH
) (
    input  wire logic                          clk_sys_i,
    input  wire logic                          rstn_i,
    input  wire logic                          serial_i,
    input  wire logic                          ordered_i,
    // local request port
    input  wire logic                          req_valid_i,
    input  wire iot_pkg::iot_kind_type         req_kind_i,
    input  wire logic [ID_W-1:0]               req_dest_i,
    input  wire logic [ADDR_W-1:0]             req_addr_i,
    input  wire logic [DATA_W-1:0]             req_data_i,
    output logic                               req_ack_o,
    output logic [$clog2(NUM_TID)-1:0]         req_tid_o,
    // completions to the local user
    output logic                               cpl_valid_o,
    output logic [$clog2(NUM_TID)-1:0]         cpl_tid_o,
    output logic                               cpl_err_o,
    output logic [DATA_W-1:0]                  cpl_data_o,
    output logic                               err_evt_o,
    // outgoing packets
    output logic                               tx_valid_o,
    input  wire logic                          tx_ready_i,
    output logic                               tx_resp_o,
    output logic [3:0]                         tx_ftype_o,
    output logic [1:0]                         tx_status_o,
    output logic [$clog2(NUM_TID)-1:0]         tx_tid_o,
    output logic [ID_W-1:0]                    tx_dest_o,
    output logic [ADDR_W-1:0]                  tx_addr_o,
    output logic [DATA_W-1:0]                  tx_data_o,
    // incoming requests
    input  wire logic                          rq_valid_i,
    output logic                               rq_ready_o,
    input  wire iot_pkg::iot_kind_type         rq_kind_i,
    input  wire logic [ID_W-1:0]               rq_src_i,
    input  wire logic [$clog2(NUM_TID)-1:0]    rq_tid_i,
    input  wire logic [ADDR_W-1:0]             rq_addr_i,
    input  wire logic [DATA_W-1:0]             rq_data_i,
    // incoming responses, always taken
    input  wire logic                          rs_valid_i,
    input  wire logic [ID_W-1:0]               rs_src_i,
    input  wire logic [$clog2(NUM_TID)-1:0]    rs_tid_i,
    input  wire logic [1:0]                    rs_status_i,
    input  wire logic [DATA_W-1:0]             rs_data_i,
    // local memory
    output logic                               mem_req_o,
    output logic                               mem_we_o,
    output logic [ADDR_W-1:0]                  mem_addr_o,
    output logic [DATA_W-1:0]                  mem_wdata_o,
    input  wire logic                          mem_ack_i,
    input  wire logic                          mem_err_i,
    input  wire logic [DATA_W-1:0]             mem_rdata_i
);
    import iot_pkg::*;

    localparam int TID_W = $clog2(NUM_TID);
    localparam int FW    = 1 + 3 + ID_W + TID_W + ADDR_W + DATA_W;

    if (NUM_TID < 2 || (1 << TID_W) != NUM_TID) begin : g_bad_tid
        $error("iot_tracker tid count must be a power of two of at least 2");
    end

    typedef enum logic [1:0] {
        R_IDLE = 2'b00,
        R_MEM  = 2'b01,
        R_SWAP = 2'b10,
        R_RESP = 2'b11
    } iot_rsp_type;

    // ************************************************************
    // requester: outstanding table
    // ************************************************************
    logic                 ent_valid_reg [NUM_TID];
    logic                 ent_flag_reg  [NUM_TID];
    iot_kind_type         ent_kind_reg  [NUM_TID];
    logic [ID_W-1:0]      ent_dest_reg  [NUM_TID];
    logic [ADDR_W-1:0]    ent_addr_reg  [NUM_TID];
    logic [DATA_W-1:0]    ent_data_reg  [NUM_TID];
    logic [TID_W-1:0]     next_tid_reg;
    logic [TID_W-1:0]     rw_ptr_reg;
    logic                 rw_active;
    logic                 busy_rw;
    logic                 needs;
    logic                 serial_ok;
    logic                 can_new;
    logic                 slot;
    logic                 pick_rsp;
    logic                 pick_rw;
    logic                 pick_new;
    logic                 rs_hit;
    logic                 rs_retry;
    logic                 rs_fin;

    // flags pending and reads/writes outstanding
    always_comb begin
        rw_active = 1'b0;
        busy_rw   = 1'b0;
        for (int i = 0; i < NUM_TID; i++) begin
            rw_active = rw_active | (ent_flag_reg[i] & ent_valid_reg[i]);
            busy_rw   = busy_rw | (ent_valid_reg[i] & (iot_class(ent_kind_reg[i]) != C_NONE));
        end
    end

    iot_rsp_type          rst_reg;

    // issue decision; new work waits while a rewind is in progress
    assign needs     = iot_needs_resp(req_kind_i);
    assign serial_ok = !serial_i || iot_class(req_kind_i) == C_NONE || !busy_rw;
    assign can_new   = req_valid_i && !req_ack_o && !rw_active && serial_ok
                       && (!needs || !ent_valid_reg[next_tid_reg]);
    assign slot      = !tx_valid_o || tx_ready_i;
    assign pick_rsp  = slot && rst_reg == R_RESP;
    assign pick_rw   = slot && !pick_rsp && rw_active
                       && ent_flag_reg[rw_ptr_reg] && ent_valid_reg[rw_ptr_reg];
    assign pick_new  = slot && !pick_rsp && can_new;

    // responses match by tid and source; strangers are only reported
    assign rs_hit   = rs_valid_i && ent_valid_reg[rs_tid_i]
                      && ent_dest_reg[rs_tid_i] == rs_src_i;
    assign rs_retry = rs_hit && rs_status_i == `IOT_ST_RETRY;
    assign rs_fin   = rs_hit && rs_status_i != `IOT_ST_RETRY;

    // table entries; a retry mark set in the cycle it is cleared survives
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < NUM_TID; i++) begin
            if (!rstn_i) begin
                ent_valid_reg[i] <= 1'b0;
                ent_flag_reg[i]  <= 1'b0;
            end else begin
                if (pick_new && needs && TID_W'(i) == next_tid_reg) begin
                    ent_valid_reg[i] <= 1'b1;
                    ent_kind_reg[i]  <= req_kind_i;
                    ent_dest_reg[i]  <= req_dest_i;
                    ent_addr_reg[i]  <= req_addr_i;
                    ent_data_reg[i]  <= req_data_i;
                end else if (rs_fin && TID_W'(i) == rs_tid_i) begin
                    ent_valid_reg[i] <= 1'b0;
                end
                if (rs_retry && ent_valid_reg[i] && (TID_W'(i) == rs_tid_i || (ordered_i
                    && (TID_W'(i) - rs_tid_i) < (next_tid_reg - rs_tid_i)))) begin
                    ent_flag_reg[i] <= 1'b1;
                end else if ((pick_rw && TID_W'(i) == rw_ptr_reg) || !ent_valid_reg[i]) begin
                    ent_flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // tids run in sequence so issue order is tid order modulo the table
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            next_tid_reg <= '0;
            rw_ptr_reg   <= '0;
        end else begin
            if (pick_new && needs) next_tid_reg <= next_tid_reg + 1'b1;
            if (rs_retry && !rw_active) begin
                rw_ptr_reg <= rs_tid_i;
            end else if (rw_active && (pick_rw || !(ent_flag_reg[rw_ptr_reg]
                         && ent_valid_reg[rw_ptr_reg]))) begin
                rw_ptr_reg <= rw_ptr_reg + 1'b1;
            end
        end
    end

    // acknowledge, completion and stray response pulses
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            req_ack_o   <= 1'b0;
            req_tid_o   <= '0;
            cpl_valid_o <= 1'b0;
            cpl_tid_o   <= '0;
            cpl_err_o   <= 1'b0;
            cpl_data_o  <= '0;
            err_evt_o   <= 1'b0;
        end else begin
            req_ack_o   <= pick_new;
            if (pick_new) req_tid_o <= needs ? next_tid_reg : '0;
            cpl_valid_o <= rs_fin;
            if (rs_fin) begin
                cpl_tid_o  <= rs_tid_i;
                cpl_err_o  <= rs_status_i == `IOT_ST_ERROR;
                cpl_data_o <= rs_data_i;
            end
            err_evt_o   <= rs_valid_i && !rs_hit;
        end
    end

    // ************************************************************
    // responder: input buffer and service machine
    // ************************************************************
    logic                 f_valid;
    logic                 f_ready;
    logic [FW-1:0]        f_data;
    logic [FW-1:0]        in_word;
    logic                 in_retry;
    logic                 in_seq;
    logic [TID_W-1:0]     exp_tid_reg;
    logic                 cur_retry;
    iot_kind_type         cur_kind;
    logic [ID_W-1:0]      cur_src;
    logic [TID_W-1:0]     cur_tid;
    logic [ADDR_W-1:0]    cur_addr;
    logic [DATA_W-1:0]    cur_data;
    logic [TID_W-1:0]     rtid_reg;
    logic [ID_W-1:0]      rsrc_reg;
    logic                 rmaint_reg;
    logic [1:0]           rstat_reg;
    logic                 rpost_reg;
    logic [DATA_W-1:0]    rdata_reg;

    // sequenced requests out of turn are marked for a retry answer at entry,
    // so the buffer waits on the output side to accept them only when it is full
    assign in_seq   = ordered_i && rq_kind_i != K_MAINT && iot_needs_resp(rq_kind_i);
    assign in_retry = in_seq && rq_tid_i != exp_tid_reg;
    assign in_word  = {in_retry, rq_kind_i, rq_src_i, rq_tid_i, rq_addr_i, rq_data_i};
    assign {cur_retry, cur_kind, cur_src, cur_tid, cur_addr, cur_data} = f_data;
    assign f_ready  = rst_reg == R_IDLE;

    iot_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_rq_fifo (
        .clk_sys_i   (clk_sys_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (rq_valid_i),
        .in_ready_o  (rq_ready_o),
        .in_data_i   (in_word),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready),
        .out_data_o  (f_data)
    );

    // expected tag advances only on an in-turn accepted request; every later
    // one keeps missing until the retried one comes back
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            exp_tid_reg <= '0;
        end else if (rq_valid_i && rq_ready_o && in_seq && !in_retry) begin
            exp_tid_reg <= exp_tid_reg + 1'b1;
        end
    end

    // service one request at a time; the next pops only after the answer left, or after the memory ack of a posted write
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rst_reg     <= R_IDLE;
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= '0;
            rtid_reg    <= '0;
            rsrc_reg    <= '0;
            rmaint_reg  <= 1'b0;
            rpost_reg   <= 1'b0;
            rstat_reg   <= `IOT_ST_DONE;
            rdata_reg   <= '0;
        end else begin
            unique case (rst_reg)
                R_IDLE: if (f_valid) begin
                    rtid_reg   <= cur_tid;
                    rsrc_reg   <= cur_src;
                    rmaint_reg <= cur_kind == K_MAINT;
                    rpost_reg  <= !iot_needs_resp(cur_kind);
                    rdata_reg  <= '0;
                    rstat_reg  <= cur_retry ? `IOT_ST_RETRY : `IOT_ST_DONE;
                    if (cur_retry || cur_kind == K_MAINT) begin
                        rst_reg <= R_RESP;
                    end else begin
                        mem_req_o   <= 1'b1;
                        mem_we_o    <= cur_kind != K_NREAD && cur_kind != K_ATOMIC;
                        mem_addr_o  <= cur_addr;
                        mem_wdata_o <= cur_data;
                        rst_reg     <= cur_kind == K_ATOMIC ? R_SWAP : R_MEM;
                    end
                end
                R_MEM: if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    if (!mem_we_o) rdata_reg <= mem_rdata_i;
                    if (mem_err_i) rstat_reg <= `IOT_ST_ERROR;
                    rst_reg <= rpost_reg ? R_IDLE : R_RESP;
                end
                R_SWAP: if (mem_ack_i) begin
                    // old value goes back, supplied value is written without a gap
                    rdata_reg <= mem_rdata_i;
                    if (mem_err_i) begin
                        mem_req_o <= 1'b0;
                        rstat_reg <= `IOT_ST_ERROR;
                        rst_reg   <= R_RESP;
                    end else begin
                        mem_we_o <= 1'b1;
                        rst_reg  <= R_MEM;
                    end
                end
                R_RESP: if (pick_rsp) rst_reg <= R_IDLE;
            endcase
        end
    end

    // ************************************************************
    // outgoing packet register
    // ************************************************************
    // answers win the slot, so remote requesters wait on our own traffic only for a packet already held in the register
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            tx_valid_o  <= 1'b0;
            tx_resp_o   <= 1'b0;
            tx_ftype_o  <= '0;
            tx_status_o <= '0;
            tx_tid_o    <= '0;
            tx_dest_o   <= '0;
            tx_addr_o   <= '0;
            tx_data_o   <= '0;
        end else if (pick_rsp) begin
            tx_valid_o  <= 1'b1;
            tx_resp_o   <= 1'b1;
            tx_ftype_o  <= rmaint_reg ? `IOT_FT_MAINT : `IOT_FT_RESP;
            tx_status_o <= rstat_reg;
            tx_tid_o    <= rtid_reg;
            tx_dest_o   <= rsrc_reg;
            tx_addr_o   <= '0;
            tx_data_o   <= rdata_reg;
        end else if (pick_rw) begin
            tx_valid_o  <= 1'b1;
            tx_resp_o   <= 1'b0;
            tx_ftype_o  <= iot_ftype(ent_kind_reg[rw_ptr_reg]);
            tx_status_o <= '0;
            tx_tid_o    <= rw_ptr_reg;
            tx_dest_o   <= ent_dest_reg[rw_ptr_reg];
            tx_addr_o   <= ent_addr_reg[rw_ptr_reg];
            tx_data_o   <= ent_data_reg[rw_ptr_reg];
        end else if (pick_new) begin
            tx_valid_o  <= 1'b1;
            tx_resp_o   <= 1'b0;
            tx_ftype_o  <= iot_ftype(req_kind_i);
            tx_status_o <= '0;
            tx_tid_o    <= needs ? next_tid_reg : '0;
            tx_dest_o   <= req_dest_i;
            tx_addr_o   <= req_addr_i;
            tx_data_o   <= req_data_i;
        end else if (tx_ready_i) begin
            tx_valid_o  <= 1'b0;
        end
    end
endmodule : iot_tracker

// ### verification/iot_tracker_monitor.sv
// iot_tracker_monitor.sv - port checks of the tracker
// assumes iot_pkg compiled first; bound below
`timescale 1ns/10ps
// ****
// checker
// ****
module iot_tracker_monitor import iot_pkg::*; (
    input wire logic         clk_sys_i, rstn_i, req_ack_o, tx_valid_o, tx_ready_i, tx_resp_o,
    input wire logic         cpl_valid_o, cpl_err_o, err_evt_o, rs_valid_i, mem_req_o, mem_ack_i,
    input wire logic [1:0]   tx_status_o, rs_status_i,
    input wire logic [3:0]   tx_ftype_o,
    input wire logic [63:0]  tx_data_o,
    input wire iot_kind_type req_kind_i
);
    // one clock, quiet in reset
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    ack_pulse_a: assert property (req_ack_o |=> !req_ack_o) else $error("long ack");
    ack_packet_a: assert property (req_ack_o |-> tx_valid_o && !tx_resp_o && tx_status_o == 2'h0)
        else $error("ack without request packet");
    fmt_stream_a: assert property (req_ack_o && $past(req_kind_i) == K_SWRITE |-> tx_ftype_o == 4'h6)
        else $error("stream format");
    fmt_maint_a: assert property (req_ack_o && $past(req_kind_i) == K_MAINT |-> tx_ftype_o == 4'h8)
        else $error("maint format");
    // refused packets stay offered
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("packet dropped");
    cpl_cause_a: assert property (cpl_valid_o |-> $past(rs_valid_i) && cpl_err_o == ($past(rs_status_i) == 2'h1))
        else $error("completion without answer");
    err_cause_a: assert property (err_evt_o |-> $past(rs_valid_i)) else $error("stray flag");
    mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o) else $error("memory access lost");
    cover property (cpl_valid_o && cpl_err_o);
    cover property (err_evt_o);
    cover property (tx_valid_o && tx_resp_o && !tx_ready_i);
endmodule : iot_tracker_monitor
bind iot_tracker iot_tracker_monitor MON (.clk_sys_i, .rstn_i, .req_ack_o, .tx_valid_o, .tx_ready_i, .tx_resp_o,
    .cpl_valid_o, .cpl_err_o, .err_evt_o, .rs_valid_i, .mem_req_o, .mem_ack_i, .tx_status_o, .rs_status_i,
    .tx_ftype_o, .tx_data_o, .req_kind_i);

// ### verification/iot_remote_model.sv
// iot_remote_model.sv - remote element across the fabric
// assumes tracker tx port; answers 3 cycles on
`timescale 1ns/10ps
// ****
// remote element
// ****
module iot_remote_model (
    input  wire logic        clk_sys_i, tx_valid_o, tx_resp_o, reply_i, stall_i, bad_i,
    input  wire logic [1:0]  tx_tid_o,
    input  wire logic [7:0]  tx_dest_o,
    input  wire logic [31:0] tx_addr_o,
    output logic             tx_ready_o = 1'h1,
    output logic             rs_valid_o = 1'h0,
    output logic [7:0]       rs_src_o,
    output logic [1:0]       rs_tid_o,
    output logic [63:0]      rs_data_o
);
    logic [63:0] data_reg;
    logic [1:0]  wait_reg = 2'h0;
    // stall toggles ready
    always @(posedge clk_sys_i) tx_ready_o <= stall_i ? ~tx_ready_o : 1'h1;
    // one answer in flight, echoing tid
    always @(posedge clk_sys_i) begin
        rs_valid_o <= (wait_reg == 2'h1);
        if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
        if (tx_valid_o && tx_ready_o && !tx_resp_o && reply_i) begin
            wait_reg <= 2'h3;
            rs_tid_o <= tx_tid_o;
            rs_src_o <= bad_i ? ~tx_dest_o : tx_dest_o;
            data_reg <= {32'h0, ~tx_addr_o};
        end
    end
    // data shows the inverse until released
    assign rs_data_o = rs_valid_o ? data_reg : ~data_reg;
endmodule : iot_remote_model

// ### verification/iot_tracker_tb.sv
// iot_tracker_tb.sv - bench of the tracker
// assumes all rtl and model files are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module iot_tracker_tb;
    import iot_pkg::*;
    logic         clk_sys_i = 0, rstn_i = 0, serial_i = 0, ordered_i = 0, req_valid_i = 0, rq_valid_i = 0;
    logic         mem_ack_i = 0, mem_err_i = 0, go = 1, reply = 0, stall = 0, bad = 0, rsp_seen;
    logic         req_ack_o, cpl_valid_o, cpl_err_o, err_evt_o, tx_valid_o, tx_ready_i, tx_resp_o, rq_ready_o;
    logic         rs_valid_i, mem_req_o;
    logic [1:0]   req_tid_o, cpl_tid_o, tx_status_o, tx_tid_o, rq_tid_i = 0, rs_tid_i, rs_status_i = 0, tid;
    logic [3:0]   tx_ftype_o;
    logic [7:0]   req_dest_i = 8'h5A, tx_dest_o, rq_src_i = 8'h22, rs_src_i;
    logic [31:0]  req_addr_i = 0, tx_addr_o, rq_addr_i = 0, mem_addr_o;
    logic [63:0]  req_data_i = 0, cpl_data_o, tx_data_o, rq_data_i = 0, rs_data_i, mem_rdata_i;
    iot_kind_type req_kind_i = K_NREAD, rq_kind_i = K_NREAD;
    int           miscompares = 0, check_count = 0, cyc = 0;
    iot_tracker DUT (.clk_sys_i, .rstn_i, .serial_i, .ordered_i, .req_valid_i, .req_kind_i, .req_dest_i,
        .req_addr_i, .req_data_i, .req_ack_o, .req_tid_o, .cpl_valid_o, .cpl_tid_o, .cpl_err_o, .cpl_data_o,
        .err_evt_o, .tx_valid_o, .tx_ready_i, .tx_resp_o, .tx_ftype_o, .tx_status_o, .tx_tid_o, .tx_dest_o,
        .tx_addr_o, .tx_data_o, .rq_valid_i, .rq_ready_o, .rq_kind_i, .rq_src_i, .rq_tid_i, .rq_addr_i,
        .rq_data_i, .rs_valid_i, .rs_src_i, .rs_tid_i, .rs_status_i, .rs_data_i, .mem_req_o, .mem_we_o(),
        .mem_addr_o, .mem_wdata_o(), .mem_ack_i, .mem_err_i, .mem_rdata_i);
    iot_remote_model FAR (.clk_sys_i, .tx_valid_o, .tx_resp_o, .reply_i(reply), .stall_i(stall), .bad_i(bad),
        .tx_tid_o, .tx_dest_o, .tx_addr_o, .tx_ready_o(tx_ready_i), .rs_valid_o(rs_valid_i), .rs_src_o(rs_src_i),
        .rs_tid_o(rs_tid_i), .rs_data_o(rs_data_i));
    // clock and local memory
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) mem_ack_i <= mem_req_o && !mem_ack_i && go;
    assign mem_rdata_i = {mem_addr_o, ~mem_addr_o};
    always_comb rsp_seen = tx_valid_o && tx_resp_o;
    task automatic tick(); @(posedge clk_sys_i) #1; endtask : tick
    // bounded wait
    task automatic await(ref logic s); int n = 0; do begin tick(); n++; end while (s !== 1'b1 && n < 60);
    endtask : await
    // local request and its completion
    task automatic send(iot_kind_type k, logic [3:0] f, logic r, logic e);
        tick(); req_kind_i = k; req_addr_i = req_addr_i + 32'h10; req_data_i = {2{req_addr_i}};
        reply = r; rs_status_i = {1'b0, e}; req_valid_i = 1;
        await(req_ack_o);
        req_valid_i = 0;
        tid = req_tid_o;
        `CHK(tx_ftype_o, f)
        if (r) begin
            await(cpl_valid_o);
            `CHK({cpl_tid_o, cpl_err_o}, {tid, e})
            if (k == K_NREAD && !e) `CHK(cpl_data_o, {32'h0, ~req_addr_i})
        end
        $display("send %s done", k.name());
    endtask : send
    // incoming request answered
    task automatic serve(iot_kind_type k, logic e);
        tick(); rq_kind_i = k; rq_tid_i = rq_tid_i + 2'h1; rq_addr_i = rq_addr_i + 32'h8; mem_err_i = e; rq_valid_i = 1;
        for (int n = 0; n < 60 && rq_ready_o !== 1'b1; n++) tick();
        tick(); rq_valid_i = 0;
        await(rsp_seen);
        `CHK({tx_ftype_o, tx_status_o, tx_tid_o}, {4'hD, 1'b0, e, rq_tid_i})
        if ((k == K_NREAD || k == K_ATOMIC) && !e) `CHK(tx_data_o, {rq_addr_i, ~rq_addr_i})
        mem_err_i = 0;
        $display("serve %s done", k.name());
    endtask : serve
    // posted writes pile up until refused
    task automatic fill(); int n = 0;
        tick(); go = 0; stall = 1; rq_kind_i = K_NWRITE; rq_valid_i = 1;
        repeat (20) begin if (rq_ready_o === 1'b1) n++; tick(); end
        rq_valid_i = 0;
        `CHK(n >= 8 && rq_ready_o === 1'b0, 1'b1)
        go = 1; repeat (60) tick();
        `CHK(rq_ready_o, 1'b1)
        stall = 0;
        $display("fill done");
    endtask : fill
    // stray answer is flagged, never completed
    task automatic stray();
        tick(); bad = 1; reply = 1; req_kind_i = K_NREAD; req_valid_i = 1;
        await(req_ack_o);
        req_valid_i = 0;
        await(err_evt_o);
        `CHK({err_evt_o, cpl_valid_o}, 2'h2)
        $display("stray done");
    endtask : stray
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // cycle ceiling
    always @(posedge clk_sys_i) begin cyc++; if (cyc == 5000) begin miscompares++; results(); end end
    initial begin
        repeat (16) tick();
        rstn_i = 1;
        send(K_NREAD, 4'h2, 1, 0); send(K_NWRITE, 4'h5, 0, 0); send(K_NWRITE_R, 4'h5, 1, 0);
        send(K_SWRITE, 4'h6, 0, 0); send(K_ATOMIC, 4'h2, 1, 0); send(K_MAINT, 4'h8, 1, 0);
        send(K_NREAD, 4'h2, 1, 1); stall = 1; send(K_NREAD, 4'h2, 1, 0); stall = 0;
        serve(K_NREAD, 0); serve(K_NREAD, 1); serve(K_NWRITE_R, 0); serve(K_ATOMIC, 0);
        fill(); stray(); results();
    end
endmodule : iot_tracker_tb
